// File: design/lkdsr_map.svh
// offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef LKDSR_MAP_SVH
`define LKDSR_MAP_SVH
// register word indexes on the plain register port
`define LKDSR_REG_STATUS 4'h0
`define LKDSR_REG_MASK 4'h1
`define LKDSR_REG_STATE 4'h2
`define LKDSR_REG_KEYDATA 4'h3
`define LKDSR_REG_CTRL 4'h4
// event bit positions in status and mask
`define LKDSR_EV_RELEASE 0
`define LKDSR_EV_KEYREQ 1
`define LKDSR_EV_DROP 2
`define LKDSR_EV_FRAME 3
`define LKDSR_EV_W 4
`define LKDSR_STATUS_RST 4'h0
`define LKDSR_MASK_RST 4'h0
// serial framing
`define LKDSR_ADDR_WR 8'h42
`define LKDSR_ADDR_RD 8'h43
`define LKDSR_ADDR_BITS 6'h08
`define LKDSR_FRAME_BITS 6'h30
`define LKDSR_CNT_SAT 6'h3F
`define LKDSR_SEL_DISP0 2'h0
`define LKDSR_SEL_DISP1 2'h1
`define LKDSR_SEL_CTRL 2'h2
// control frame bit positions inside the frame shift register
`define LKDSR_CTL_SLEEP_LO 8
`define LKDSR_CTL_SLEEP_HI 9
`define LKDSR_CTL_SEG_OFF 10
`define LKDSR_CTL_KEY_SHARED 11
// pin levels
`define LKDSR_LINES_RESET 6'h20
`define LKDSR_LINES_ALL 6'h3F
`define LKDSR_SLEEP_ONLY_LAST 2'h2
// timing
`define LKDSR_CLK_NS 25
`define LKDSR_SCAN_STEP_NS 1000
`define LKDSR_SCAN_STEP_CYC ((`LKDSR_SCAN_STEP_NS + `LKDSR_CLK_NS - 1) / `LKDSR_CLK_NS)
`define LKDSR_COM_STEP_NS 2000
`define LKDSR_COM_STEP_CYC ((`LKDSR_COM_STEP_NS + `LKDSR_CLK_NS - 1) / `LKDSR_CLK_NS)
`endif

// File: design/lkdsr_pkg.sv
// types shared by the reset sequencer modules
package lkdsr_pkg;
	typedef enum logic [2:0] {
		KS_IDLE = 3'b001,
		KS_SCAN = 3'b010,
		KS_WAIT = 3'b100
	} lkdsr_scan_t;
endpackage : lkdsr_pkg

// File: design/lkdsr_keyscan.sv
// key scan sequencer with double-scan agreement and key buffer
`timescale 1ns/1ps
`include "lkdsr_map.svh"
module lkdsr_keyscan import lkdsr_pkg::*; #(
	parameter int STEP = `LKDSR_SCAN_STEP_CYC
) (
	input wire logic mclk, // system clock
	input wire logic rst, // async reset, high
	input wire logic clk_en, // freezes state when low
	input wire logic hold, // system reset held
	input wire logic [4:0] key_return_line, // synchronised key returns
	input wire logic [1:0] sleep_sel, // {high, low} sleep select
	input wire logic shared_key, // shared pins act as scan lines
	input wire logic rd_clear, // key data read finished
	output logic [5:0] key_scan_line, // scan line levels
	output logic [29:0] key_data, // key buffer
	output logic key_req, // key data read request
	output logic key_active // scan in progress or key data read pending
);
	// ****************************************
	// scan datapath
	// ****************************************
	localparam logic [15:0] STEP_LAST = 16'(STEP - 1);
	generate
		if (STEP < 4 || STEP > 65535) begin : g_bad_step
			$error("scan step must cover the return synchroniser");
		end
	endgenerate

	lkdsr_scan_t state;
	logic [15:0] step_cnt;
	logic [2:0] line_idx;
	logic pass;
	logic [29:0] cur;
	logic [29:0] first;

	wire line_ok = shared_key | (line_idx > 3'd1);
	wire [4:0] row_val = line_ok ? key_return_line : 5'h00;
	wire [29:0] cur_next = cur | 30'({25'h0, row_val} << (5'(line_idx) * 5'd5));
	wire step_end = (step_cnt == STEP_LAST);
	wire last_line = (line_idx == 3'd5);
	wire [5:0] scan_lines = line_ok ? 6'(6'h01 << line_idx) : 6'h00;
	wire sleep_on = |sleep_sel;
	wire [5:0] idle_lines = (sleep_on && sleep_sel == `LKDSR_SLEEP_ONLY_LAST) ?
		`LKDSR_LINES_RESET : `LKDSR_LINES_ALL;
	wire [5:0] next_lines = hold ? `LKDSR_LINES_RESET :
		(state == KS_SCAN ? scan_lines : idle_lines);
	assign key_active = (state != KS_IDLE);

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= KS_IDLE;
			step_cnt <= 16'h0000;
			line_idx <= 3'h0;
			pass <= 1'b0;
			cur <= 30'h00000000;
			first <= 30'h00000000;
			key_data <= 30'h00000000;
			key_req <= 1'b0;
			key_scan_line <= `LKDSR_LINES_RESET;
		end else if (clk_en) begin
			key_scan_line <= next_lines;
			if (hold) begin
				// back to initial state, buffer cleared, scan disabled
				state <= KS_IDLE;
				step_cnt <= 16'h0000;
				line_idx <= 3'h0;
				pass <= 1'b0;
				cur <= 30'h00000000;
				first <= 30'h00000000;
				key_data <= 30'h00000000;
				key_req <= 1'b0;
			end else begin
				unique case (state)
					KS_IDLE: begin
						if (|key_return_line) begin
							state <= KS_SCAN;
							step_cnt <= 16'h0000;
							line_idx <= 3'h0;
							pass <= 1'b0;
							cur <= 30'h00000000;
						end
					end
					KS_SCAN: begin
						if (!step_end) begin
							step_cnt <= step_cnt + 16'h0001;
						end else if (!last_line) begin
							step_cnt <= 16'h0000;
							line_idx <= line_idx + 3'h1;
							cur <= cur_next;
						end else begin
							step_cnt <= 16'h0000;
							line_idx <= 3'h0;
							cur <= 30'h00000000;
							if (pass && cur_next == first) begin
								if (cur_next == 30'h00000000) begin
									state <= KS_IDLE;
								end else begin
									key_data <= cur_next;
									key_req <= 1'b1;
									state <= KS_WAIT;
								end
							end else begin
								first <= cur_next;
								pass <= 1'b1;
							end
						end
					end
					KS_WAIT: begin
						if (rd_clear) begin
							key_req <= 1'b0;
							state <= KS_SCAN;
							step_cnt <= 16'h0000;
							line_idx <= 3'h0;
							pass <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_hold_clears_keys: assert property (@(posedge mclk) disable iff (rst)
		hold && clk_en |=> key_data == 30'h00000000 && !key_req && state == KS_IDLE)
		else $error("key buffer not cleared under reset");
	a_hold_last_line: assert property (@(posedge mclk) disable iff (rst)
		hold && clk_en |=> key_scan_line == `LKDSR_LINES_RESET)
		else $error("scan lines wrong under reset");
endmodule : lkdsr_keyscan

// File: design/lkdsr_top.sv
// system reset sequencer of the lcd driver with key scan
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lkdsr_map.svh"
module lkdsr_top import lkdsr_pkg::*; #(
	parameter int COM_STEP = `LKDSR_COM_STEP_CYC,
	parameter int SCAN_STEP = `LKDSR_SCAN_STEP_CYC
) (
	input wire logic mclk, // system clock
	input wire logic rst, // async reset, high
	input wire logic clk_en, // freezes state when low
	input wire logic supply_drop_detector, // high while supply at or below threshold
	input wire logic ce_pin, // serial chip enable
	input wire logic cl_pin, // serial clock
	input wire logic di_pin, // serial data in
	input wire logic [4:0] key_return_line, // key matrix returns
	output logic do_o, // key request pin level when driven
	output logic do_oe, // drive key request pin low
	output logic [3:0] key_scan_upper, // scan lines three to six
	output logic [1:0] shared_scan_segment_pin, // shared scan/segment pins
	output logic [3:0] segment_port_pin, // segment/port pins
	output logic [18:0] seg_out, // plain segment pins
	output logic [2:0] common_drive, // common pins
	output logic osc_run, // oscillator running
	input wire logic [3:0] reg_addr, // register index
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output logic irq // level interrupt
);
	// ****************************************
	// parameter checks and helpers
	// ****************************************
	generate
		if (COM_STEP < 1 || COM_STEP > 65535) begin : g_bad_com
			$error("common step out of range");
		end
	endgenerate
	localparam logic [15:0] COM_LAST = 16'(COM_STEP - 1);

	function automatic logic pick3(input logic [2:0] bits, input logic [1:0] idx);
		pick3 = (idx == 2'd0) ? bits[0] : (idx == 2'd1) ? bits[1] : bits[2];
	endfunction : pick3

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [8:0] sy1;
	logic [8:0] sy2;
	wire [8:0] pins_in = {key_return_line, supply_drop_detector, di_pin, cl_pin, ce_pin};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sy1 <= 9'h000;
			sy2 <= 9'h000;
		end else if (clk_en) begin
			sy1 <= pins_in;
			sy2 <= sy1;
		end
	end
	wire ce_s = sy2[0];
	wire cl_s = sy2[1];
	wire di_s = sy2[2];
	wire drop_s = sy2[3];
	wire [4:0] ret_s = sy2[8:4];

	// ****************************************
	// serial interface
	// ****************************************
	logic ce_d;
	logic cl_d;
	logic [47:0] sr;
	logic [5:0] bit_cnt;
	logic rd_mode;
	logic [30:0] out_sr;
	logic in_reset;
	logic [1:0] sleep_sel;
	logic [29:0] key_data;
	logic key_req;
	logic key_active;
	logic [5:0] key_lines;

	wire cl_rise = cl_s & ~cl_d;
	wire cl_fall = ~cl_s & cl_d;
	wire ce_fall = ~ce_s & ce_d;
	wire shift_en = ce_s & cl_rise;
	wire rd_hit = ce_s & ~rd_mode & (bit_cnt == `LKDSR_ADDR_BITS) & (sr[47:40] == `LKDSR_ADDR_RD);
	wire frame_ok = ce_fall & (bit_cnt == `LKDSR_FRAME_BITS) & (sr[7:0] == `LKDSR_ADDR_WR);
	wire [1:0] frame_sel = sr[47:46];
	wire commit_d0 = frame_ok & (frame_sel == `LKDSR_SEL_DISP0);
	wire commit_d1 = frame_ok & (frame_sel == `LKDSR_SEL_DISP1);
	wire commit_ctl = frame_ok & (frame_sel == `LKDSR_SEL_CTRL);
	wire commit_any = commit_d0 | commit_d1 | commit_ctl;
	wire rd_done = ce_fall & rd_mode;
	wire sleep_on = |sleep_sel;

	// shift and count keep running whatever the system reset does
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ce_d <= 1'b0;
			cl_d <= 1'b0;
			sr <= 48'h000000000000;
			bit_cnt <= 6'h00;
			rd_mode <= 1'b0;
			out_sr <= 31'h00000000;
		end else if (clk_en) begin
			ce_d <= ce_s;
			cl_d <= cl_s;
			if (ce_fall) begin
				bit_cnt <= 6'h00;
				rd_mode <= 1'b0;
			end else if (shift_en) begin
				sr <= {di_s, sr[47:1]};
				if (bit_cnt != `LKDSR_CNT_SAT) begin
					bit_cnt <= bit_cnt + 6'h01;
				end
			end
			if (rd_hit) begin
				rd_mode <= 1'b1;
				out_sr <= {sleep_on, key_data};
			end else if (rd_mode && cl_fall) begin
				out_sr <= {1'b0, out_sr[30:1]};
			end
		end
	end

	// request low when idle, data bits during a read, released in reset
	wire next_do_oe = in_reset ? 1'b0 :
		!ce_s ? key_req :
		!rd_mode ? 1'b0 :
		cl_fall ? ~out_sr[0] : do_oe;

	// ****************************************
	// display latch and control register
	// ****************************************
	logic [74:0] disp;
	logic seg_off;
	logic key_shared;
	logic ctrl_seen;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			disp <= 75'h0;
			sleep_sel <= 2'h0;
			seg_off <= 1'b0;
			key_shared <= 1'b0;
			ctrl_seen <= 1'b0;
		end else if (clk_en) begin
			if (commit_d0) begin
				disp[37:0] <= sr[45:8];
			end
			if (commit_d1) begin
				disp[74:38] <= sr[44:8];
			end
			if (commit_ctl) begin
				sleep_sel <= {sr[`LKDSR_CTL_SLEEP_HI], sr[`LKDSR_CTL_SLEEP_LO]};
				seg_off <= sr[`LKDSR_CTL_SEG_OFF];
				key_shared <= sr[`LKDSR_CTL_KEY_SHARED];
				ctrl_seen <= 1'b1;
			end
		end
	end

	// ****************************************
	// reset sequencing
	// ****************************************
	logic [2:0] recs;
	logic soft_reset;
	wire hold_req = drop_s | soft_reset;
	wire [2:0] next_recs = recs | {commit_ctl, commit_d1, commit_d0};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			in_reset <= 1'b1;
			recs <= 3'h0;
		end else if (clk_en) begin
			if (hold_req) begin
				in_reset <= 1'b1;
				recs <= 3'h0;
			end else begin
				recs <= next_recs;
				if (in_reset && ce_fall && (&next_recs)) begin
					in_reset <= 1'b0;
				end
			end
		end
	end

	lkdsr_keyscan #(.STEP(SCAN_STEP)) u_keyscan (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.hold(in_reset),
		.key_return_line(ret_s),
		.sleep_sel(sleep_sel),
		.shared_key(key_shared),
		.rd_clear(rd_done & ~in_reset),
		.key_scan_line(key_lines),
		.key_data(key_data),
		.key_req(key_req),
		.key_active(key_active)
	);
	assign key_scan_upper = key_lines[5:2];

	// ****************************************
	// base clock and drivers
	// ****************************************
	logic [15:0] com_cnt;
	logic [1:0] com_idx;
	logic [24:0] seg_q;
	wire next_osc = ctrl_seen & (~sleep_on | key_active);
	wire base_run = osc_run & ~in_reset;
	wire disp_run = base_run & ~sleep_on;
	wire seg_en = disp_run & ~seg_off;
	wire [24:0] next_seg;
	genvar g;
	generate
		for (g = 0; g < 25; g++) begin : g_seg
			assign next_seg[g] = seg_en & pick3(disp[g*3 +: 3], com_idx);
		end
	endgenerate
	wire [2:0] next_com = disp_run ? 3'(3'b001 << com_idx) : 3'b000;
	wire [1:0] next_shared = in_reset ? 2'b00 :
		key_shared ? key_lines[1:0] : next_seg[24:23];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			com_cnt <= 16'h0000;
			com_idx <= 2'h0;
			seg_q <= 25'h0000000;
			common_drive <= 3'h0;
			shared_scan_segment_pin <= 2'h0;
			osc_run <= 1'b0;
			do_oe <= 1'b0;
		end else if (clk_en) begin
			osc_run <= next_osc;
			do_oe <= next_do_oe;
			seg_q <= next_seg;
			common_drive <= next_com;
			shared_scan_segment_pin <= next_shared;
			if (disp_run) begin
				if (com_cnt == COM_LAST) begin
					com_cnt <= 16'h0000;
					com_idx <= (com_idx == 2'd2) ? 2'd0 : com_idx + 2'd1;
				end else begin
					com_cnt <= com_cnt + 16'h0001;
				end
			end
		end
	end
	assign segment_port_pin = seg_q[3:0];
	assign seg_out = seg_q[22:4];
	assign do_o = 1'b0;

	// ****************************************
	// register port and interrupt
	// ****************************************
	logic [`LKDSR_EV_W-1:0] status;
	logic [`LKDSR_EV_W-1:0] mask;
	logic in_reset_d;
	logic key_req_d;
	logic drop_d;
	wire [`LKDSR_EV_W-1:0] ev = {commit_any, drop_s & ~drop_d, key_req & ~key_req_d,
		in_reset_d & ~in_reset};
	wire wr_status = reg_wr & (reg_addr == `LKDSR_REG_STATUS);
	wire wr_mask = reg_wr & (reg_addr == `LKDSR_REG_MASK);
	wire wr_ctrl = reg_wr & (reg_addr == `LKDSR_REG_CTRL);
	wire [`LKDSR_EV_W-1:0] clr = wr_status ? reg_wdata[`LKDSR_EV_W-1:0] : 4'h0;
	wire [`LKDSR_EV_W-1:0] next_status = (status & ~clr) | ev;
	wire [31:0] state_word = {24'h0, key_req, sleep_sel, ctrl_seen, recs, in_reset};
	wire [31:0] rd_word =
		(reg_addr == `LKDSR_REG_STATUS) ? {28'h0, status} :
		(reg_addr == `LKDSR_REG_MASK) ? {28'h0, mask} :
		(reg_addr == `LKDSR_REG_STATE) ? state_word :
		(reg_addr == `LKDSR_REG_KEYDATA) ? {2'h0, key_data} :
		(reg_addr == `LKDSR_REG_CTRL) ? {31'h0, soft_reset} : 32'h00000000;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status <= `LKDSR_STATUS_RST;
			mask <= `LKDSR_MASK_RST;
			soft_reset <= 1'b0;
			in_reset_d <= 1'b1;
			key_req_d <= 1'b0;
			drop_d <= 1'b0;
			reg_rdata <= 32'h00000000;
			irq <= 1'b0;
		end else if (clk_en) begin
			in_reset_d <= in_reset;
			key_req_d <= key_req;
			drop_d <= drop_s;
			status <= next_status;
			irq <= |(status & mask);
			reg_rdata <= reg_rd ? rd_word : 32'h00000000;
			if (wr_mask) begin
				mask <= reg_wdata[`LKDSR_EV_W-1:0];
			end
			if (wr_ctrl) begin
				soft_reset <= reg_wdata[0];
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_reset_blanks_pins: assert property (@(posedge mclk) disable iff (rst)
		in_reset && clk_en |=> seg_q == 25'h0 && common_drive == 3'h0 &&
			shared_scan_segment_pin == 2'h0)
		else $error("pins not low under reset");
	a_drop_sets_reset: assert property (@(posedge mclk) disable iff (rst)
		drop_s && clk_en |=> in_reset && recs == 3'h0)
		else $error("supply drop did not hold reset");
	a_release_needs_all: assert property (@(posedge mclk) disable iff (rst)
		$fell(in_reset) |-> $past(ce_fall) && (&recs))
		else $error("reset released without all transfers");
	a_release_on_fall: assert property (@(posedge mclk) disable iff (rst)
		in_reset && !hold_req && ce_fall && (&next_recs) && clk_en |=> !in_reset)
		else $error("reset not released on last chip-enable fall");
	a_base_clock_stop: assert property (@(posedge mclk) disable iff (rst)
		in_reset && clk_en |=> $stable(com_idx) && $stable(com_cnt))
		else $error("base clock ran during reset");
	a_latch_in_reset: assert property (@(posedge mclk) disable iff (rst)
		commit_d0 && clk_en |=> disp[37:0] == $past(sr[45:8]))
		else $error("display bits not latched");
	a_do_released: assert property (@(posedge mclk) disable iff (rst)
		in_reset && clk_en |=> !do_oe)
		else $error("key request driven during reset");
	a_request_low: assert property (@(posedge mclk) disable iff (rst)
		!in_reset && !ce_s && key_req && clk_en |=> do_oe)
		else $error("pending request not signalled");
	a_sleep_select: assert property (@(posedge mclk) disable iff (rst)
		commit_ctl && clk_en |=> sleep_on == ($past(sr[9]) | $past(sr[8])))
		else $error("sleep select not taken");
	a_serial_in_reset: assert property (@(posedge mclk) disable iff (rst)
		in_reset && shift_en && !ce_fall && bit_cnt != `LKDSR_CNT_SAT && clk_en
			|=> bit_cnt == $past(bit_cnt) + 6'h01)
		else $error("serial shift stalled by reset");
	c_release: cover property (@(posedge mclk) disable iff (rst) $fell(in_reset));
	c_key_request: cover property (@(posedge mclk) disable iff (rst) $rose(key_req));
	c_key_read: cover property (@(posedge mclk) disable iff (rst) rd_done && !in_reset);
	c_read_in_reset: cover property (@(posedge mclk) disable iff (rst) rd_done && in_reset);
endmodule : lkdsr_top

// File: sim/lkdsr_ctrl_model.sv
// system controller model on the three-wire serial link
`timescale 1ns/1ps
`include "lkdsr_map.svh"
module lkdsr_ctrl_model (
	output logic ce_pin, // chip enable
	output logic cl_pin, // serial clock, still outside frames
	output logic di_pin, // serial data
	input wire logic do_pin // key request / data pin level
);
	// ****************************************
	// frame tasks
	// ****************************************
	initial begin
		ce_pin = 1'b0;
		cl_pin = 1'b0;
		di_pin = 1'b0;
	end
	task automatic pulse(input logic b);
		di_pin = b;
		#100 cl_pin = 1'b1;
		#100 cl_pin = 1'b0;
	endtask : pulse
	task automatic frame_begin();
		#37 ce_pin = 1'b1; // odd offset keeps phase unrelated to mclk
	endtask : frame_begin
	task automatic frame_end();
		#100 ce_pin = 1'b0;
		di_pin = ~di_pin; // released line must not hold its last value
		#300;
	endtask : frame_end
	// lsb first, address byte leads
	task automatic send(input logic [47:0] f);
		frame_begin();
		for (int i = 0; i < 48; i++) begin
			pulse(f[i]);
		end
		frame_end();
	endtask : send
	task automatic read_keys(output logic [30:0] kd, output logic usable);
		logic [7:0] a;
		a = `LKDSR_ADDR_RD;
		frame_begin();
		for (int i = 0; i < 8; i++) begin
			pulse(a[i]);
		end
		for (int i = 0; i < 31; i++) begin
			di_pin = ~di_pin;
			#100 cl_pin = 1'b1;
			#99 kd[i] = do_pin;
			#1 cl_pin = 1'b0;
		end
		usable = $countones(kd[29:0]) < 3;
		frame_end();
	endtask : read_keys
endmodule : lkdsr_ctrl_model

// File: sim/tb_lkdsr_top.sv
// self-checking bench of the system reset sequencer
`timescale 1ns/1ps
`include "lkdsr_map.svh"
module tb_lkdsr_top import lkdsr_pkg::*;;
	// ****************************************
	// design, controller and key matrix
	// ****************************************
	logic mclk, rst, supply_drop_detector, ce_pin, cl_pin, di_pin, key_pressed;
	logic do_o, do_oe, osc_run, reg_wr, reg_rd, irq, ok, clk_en;
	logic [4:0] key_return_line;
	logic [3:0] key_scan_upper, segment_port_pin, reg_addr;
	logic [1:0] shared_scan_segment_pin;
	logic [18:0] seg_out;
	logic [2:0] common_drive;
	logic [31:0] reg_wdata, reg_rdata, got;
	logic [30:0] kd;
	int miscompares = 0;
	int n_compared = 0;
	// one key on the sixth scan line, first return
	assign key_return_line = {4'h0, key_scan_upper[3] & key_pressed};
	lkdsr_top #(.COM_STEP(4), .SCAN_STEP(4)) i_lkdsr_top (.mclk(mclk), .rst(rst),
		.clk_en(clk_en), .supply_drop_detector(supply_drop_detector), .ce_pin(ce_pin),
		.cl_pin(cl_pin), .di_pin(di_pin), .key_return_line(key_return_line), .do_o(do_o),
		.do_oe(do_oe), .key_scan_upper(key_scan_upper),
		.shared_scan_segment_pin(shared_scan_segment_pin),
		.segment_port_pin(segment_port_pin), .seg_out(seg_out), .common_drive(common_drive),
		.osc_run(osc_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	lkdsr_ctrl_model i_lkdsr_ctrl_model (.ce_pin(ce_pin), .cl_pin(cl_pin), .di_pin(di_pin),
		.do_pin(!do_oe));
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	function automatic logic [47:0] fr(input logic [1:0] sel, input logic [37:0] d);
		return {sel, d, `LKDSR_ADDR_WR};
	endfunction : fr
	// pins low, sixth scan line high, key pin released, oscillator as given
	task automatic blanked(input logic osc);
		#1 check({1'b0, seg_out, segment_port_pin, shared_scan_segment_pin, common_drive,
			key_scan_upper[3], do_oe, osc_run}, {31'h2, osc});
	endtask : blanked
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// ****************************************
	// clock, watchdog and tests
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end
	initial begin
		int n;
		rst = 1'b1;
		clk_en = 1'b1;
		supply_drop_detector = 1'b0;
		key_pressed = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		reg_write(`LKDSR_REG_STATUS, 32'hF);
		blanked(1'b0);
		reg_read(`LKDSR_REG_STATE, got);
		check(got, 32'h1);
		key_pressed <= 1'b1;
		repeat (200) @(posedge mclk);
		i_lkdsr_ctrl_model.read_keys(kd, ok);
		check({1'b0, kd}, 32'h7FFFFFFF);
		check({31'h0, ok}, 32'h0);
		reg_read(`LKDSR_REG_KEYDATA, got);
		check(got, 32'h0);
		key_pressed <= 1'b0;
		i_lkdsr_ctrl_model.send(fr(`LKDSR_SEL_DISP0, 38'h15_5555_5555));
		reg_read(`LKDSR_REG_STATE, got);
		check(got, 32'h3);
		blanked(1'b0);
		i_lkdsr_ctrl_model.send(fr(`LKDSR_SEL_DISP1, 38'h0A_AAAA_AAAA));
		reg_read(`LKDSR_REG_STATE, got);
		check(got, 32'h7);
		i_lkdsr_ctrl_model.send(fr(`LKDSR_SEL_CTRL, 38'h0));
		reg_read(`LKDSR_REG_STATE, got);
		check(got, 32'h1E);
		reg_read(`LKDSR_REG_STATUS, got);
		check(got, 32'h9);
		#1 check({31'h0, osc_run}, 32'h1);
		n = 0;
		while (common_drive !== 3'h1 && n < 40) begin
			@(posedge mclk);
			#1 n++;
		end
		check({28'h0, segment_port_pin}, 32'h5);
		reg_write(`LKDSR_REG_MASK, 32'h1);
		repeat (3) @(posedge mclk);
		#1 check({30'h0, do_o, irq}, 32'h1);
		reg_write(`LKDSR_REG_STATUS, 32'h9);
		repeat (3) @(posedge mclk);
		#1 check({31'h0, irq}, 32'h0);
		clk_en <= 1'b0;
		reg_write(`LKDSR_REG_MASK, 32'hF);
		clk_en <= 1'b1;
		reg_read(`LKDSR_REG_MASK, got);
		check(got, 32'h1);
		key_pressed <= 1'b1;
		n = 0;
		while (do_oe !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		#1 check({31'h0, do_oe}, 32'h1);
		reg_read(`LKDSR_REG_KEYDATA, got);
		check(got, 32'h0200_0000);
		i_lkdsr_ctrl_model.read_keys(kd, ok);
		key_pressed <= 1'b0;
		check({1'b0, kd}, 32'h0200_0000);
		check({31'h0, ok}, 32'h1);
		for (int c = 1; c < 5; c++) begin
			i_lkdsr_ctrl_model.send(fr(`LKDSR_SEL_CTRL, 38'(c % 4)));
			reg_read(`LKDSR_REG_STATE, got);
			check({30'h0, got[6:5]}, 32'(c % 4));
			check({31'h0, common_drive == 3'h0}, 32'(c != 4));
		end
		supply_drop_detector <= 1'b1;
		repeat (8) @(posedge mclk);
		blanked(1'b1);
		supply_drop_detector <= 1'b0;
		reg_read(`LKDSR_REG_STATE, got);
		check(got, 32'h11);
		reg_read(`LKDSR_REG_STATUS, got);
		check({31'h0, got[`LKDSR_EV_DROP]}, 32'h1);
		reg_read(4'hF, got);
		check(got, 32'h0);
		complete_run();
	end
endmodule : tb_lkdsr_top
